// ### inc/mmx_dec_if.sv
`default_nettype none
interface mmx_dec_if;
	logic [47:0] instr;
	logic simd;
	logic bcast;
	logic short_w;
	logic [31:0] idx_val;
	logic [2:0] idx_sel;
	logic ok;
	logic [5:0] size_bits;
	logic space;
	logic dir;
	logic lw;
	logic [4:0] ureg;
	logic y_en;
	logic [31:0] addr_x;
	logic [31:0] addr_y;
	modport dec (input instr, simd, bcast, short_w, idx_val,
		output idx_sel, ok, size_bits, space, dir, lw, ureg, y_en, addr_x, addr_y);
	modport exe (output instr, simd, bcast, short_w, idx_val,
		input idx_sel, ok, size_bits, space, dir, lw, ureg, y_en, addr_x, addr_y);
endinterface
`default_nettype wire

// ### inc/mmx_pkg.sv
`default_nettype none
package mmx_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_INSTR_LO = 8'h00;
	localparam logic [7:0] OFS_INSTR_HI = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_USEL = 8'h10;
	localparam logic [7:0] OFS_UREG_X = 8'h14;
	localparam logic [7:0] OFS_UREG_Y = 8'h18;
	// Control and status bits
	localparam int CTRL_START = 0;
	localparam int CTRL_SIMD = 1;
	localparam int CTRL_BCAST = 2;
	localparam int CTRL_SHORT = 3;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ERR = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	// Instruction word fields
	localparam int F_OP = 44;
	localparam int F_SFX = 42;
	localparam int F_SPACE = 41;
	localparam int F_DIR = 40;
	localparam int F_LW = 39;
	localparam int F_UREG = 34;
	localparam int F_IDX = 32;
	localparam int IMM7_W = 7;
	localparam logic [3:0] OP_DIRECT = 4'he;
	localparam logic [3:0] OP_INDIRECT = 4'hf;
	localparam logic [1:0] SFX_A = 2'h0;
	localparam logic [1:0] SFX_B = 2'h1;
	localparam logic [1:0] SFX_C = 2'h2;
	localparam logic [5:0] SIZE_A = 6'h30;
	localparam logic [5:0] SIZE_B = 6'h20;
	localparam logic [5:0] SIZE_C = 6'h10;
	// Universal register map: 0..7 index, 8..19 have complements
	localparam logic [4:0] UREG_COMP_LO = 5'h08;
	localparam logic [4:0] UREG_COMP_HI = 5'h13;
	localparam logic [1:0] UREG_IDX_TOP = 2'h0;
	// Second element address skew
	localparam logic [31:0] K_BCAST = 32'h0;
	localparam logic [31:0] K_NW = 32'h1;
	localparam logic [31:0] K_SW = 32'h2;

	function automatic logic has_comp(input logic [4:0] u);
		return (u >= UREG_COMP_LO) && (u <= UREG_COMP_HI);
	endfunction
endpackage
`default_nettype wire

// ### rtl/mmx_decode.sv
`default_nettype none
module mmx_decode
(
	mmx_dec_if.dec d
);
	wire [3:0] op = d.instr[mmx_pkg::F_OP +: 4];
	wire [1:0] sfx = d.instr[mmx_pkg::F_SFX +: 2];
	wire is_dir = (op == mmx_pkg::OP_DIRECT) && (sfx == mmx_pkg::SFX_A);
	wire is_ind_a = (op == mmx_pkg::OP_INDIRECT) && (sfx == mmx_pkg::SFX_A);
	wire is_ind_b = (op == mmx_pkg::OP_INDIRECT) && (sfx == mmx_pkg::SFX_B);
	wire [31:0] imm;
	wire [31:0] base;
	wire [31:0] k;
	wire same_gen;
	localparam int IMM7_W_M1 = mmx_pkg::IMM7_W - 1;

	assign d.size_bits = (sfx == mmx_pkg::SFX_A) ? mmx_pkg::SIZE_A :
		(sfx == mmx_pkg::SFX_B) ? mmx_pkg::SIZE_B :
		(sfx == mmx_pkg::SFX_C) ? mmx_pkg::SIZE_C : 6'h0;
	assign d.space = d.instr[mmx_pkg::F_SPACE];
	assign d.dir = d.instr[mmx_pkg::F_DIR];
	assign d.lw = d.instr[mmx_pkg::F_LW];
	assign d.ureg = d.instr[mmx_pkg::F_UREG +: 5];
	// Data space picks the first generator, program space the second
	assign d.idx_sel = {d.space, d.instr[mmx_pkg::F_IDX +: 2]};
	// Short form keeps only seven bits, zero extended
	assign imm = is_ind_b ? {25'h0, d.instr[IMM7_W_M1:0]} : d.instr[31:0];
	assign base = is_dir ? 32'h0 : d.idx_val;
	assign d.addr_x = base + imm;
	assign k = d.bcast ? mmx_pkg::K_BCAST :
		(d.short_w ? mmx_pkg::K_SW : mmx_pkg::K_NW);
	assign d.addr_y = d.addr_x + k;
	// Index register of the same generator as the move is refused
	assign same_gen = (d.ureg[4:3] == mmx_pkg::UREG_IDX_TOP) && (d.ureg[2] == d.space);
	assign d.ok = is_dir | ((is_ind_a | is_ind_b) & ~same_gen);
	assign d.y_en = d.simd & mmx_pkg::has_comp(d.ureg);
endmodule // mmx_decode
`default_nettype wire

// ### rtl/mmx_exec.sv
`default_nettype none
module mmx_exec
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_mem_req,
	input wire logic i_mem_ack,
	output logic o_mem_space,
	output logic o_mem_we,
	output logic o_mem_lw,
	output logic o_mem_pe,
	output logic [31:0] o_mem_addr,
	output logic [31:0] o_mem_wdata,
	input wire logic [31:0] i_mem_rdata,
	output logic [5:0] o_instr_size
);
	typedef enum logic [1:0] {S_IDLE, S_X, S_Y} mmx_state_t;

	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	mmx_state_t state_q;
	mmx_state_t state_d;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [31:0] instr_lo_q;
	logic [15:0] instr_hi_q;
	logic [2:0] ctrl_q;
	logic [4:0] usel_q;
	logic done_q;
	logic err_q;
	logic [31:0] addr_q;
	logic [31:0] addr_y_q;
	logic [31:0] wdata_q;
	logic pe_q;
	logic space_q;
	logic we_q;
	logic lw_q;
	logic [31:0] ra_x;
	logic [31:0] ra_y;
	logic [31:0] rb_x;
	logic [31:0] rb_y;
	logic [31:0] ri;
	logic [31:0] rd_mux;

	mmx_dec_if dec_bus ();

	// Bus slave: one wait cycle on every access
	wire req = i_avs_read | i_avs_write;
	wire wr_go = i_avs_write & ack_q;
	wire rd_go = i_avs_read & ~ack_q;
	wire idle = (state_q == S_IDLE);
	// Writes other than status are dropped while a move runs
	wire wr_ok = wr_go & idle;
	wire sel_lo = (i_avs_address == mmx_pkg::OFS_INSTR_LO);
	wire sel_hi = (i_avs_address == mmx_pkg::OFS_INSTR_HI);
	wire sel_ctrl = (i_avs_address == mmx_pkg::OFS_CTRL);
	wire sel_stat = (i_avs_address == mmx_pkg::OFS_STATUS);
	wire sel_usel = (i_avs_address == mmx_pkg::OFS_USEL);
	wire sel_ux = (i_avs_address == mmx_pkg::OFS_UREG_X);
	wire sel_uy = (i_avs_address == mmx_pkg::OFS_UREG_Y);
	wire start_go = wr_ok & sel_ctrl & i_avs_byteenable[0]
		& i_avs_writedata[mmx_pkg::CTRL_START];
	wire launch = start_go & dec_bus.ok;
	wire [31:0] ctrl_wr = be_merge({28'h0, ctrl_q, 1'b0}, i_avs_writedata, i_avs_byteenable);
	// Mode written together with start steers that same move, not the next one
	wire [2:0] mode_now = (wr_ok & sel_ctrl) ? ctrl_wr[3:1] : ctrl_q;
	wire [31:0] hi_wr = be_merge({16'h0, instr_hi_q}, i_avs_writedata, i_avs_byteenable);
	wire [31:0] stat_wr = be_merge(32'h0, i_avs_writedata, i_avs_byteenable);
	wire clr_done = wr_go & sel_stat & stat_wr[mmx_pkg::ST_DONE];
	wire clr_err = wr_go & sel_stat & stat_wr[mmx_pkg::ST_ERR];
	wire x_ack = (state_q == S_X) & i_mem_ack;
	wire y_ack = (state_q == S_Y) & i_mem_ack;
	wire move_end = (x_ack & ~dec_bus.y_en) | y_ack;
	// Set wins over a clear in the same cycle
	wire done_d = move_end | (done_q & ~clr_done);
	wire err_d = (start_go & ~dec_bus.ok) | (err_q & ~clr_err);
	wire wx_mem = x_ack & ~dec_bus.dir;
	wire wy_mem = y_ack & ~dec_bus.dir;
	wire wx_sw = wr_ok & sel_ux;
	wire wy_sw = wr_ok & sel_uy;
	wire [31:0] w_data = (wx_mem | wy_mem) ? i_mem_rdata
		: be_merge(wx_sw ? rb_x : rb_y, i_avs_writedata, i_avs_byteenable);
	wire [4:0] w_addr = idle ? usel_q : dec_bus.ureg;

	assign o_avs_waitrequest = req & ~ack_q;
	assign o_avs_readdata = rdata_q;

	assign rd_mux = sel_lo ? instr_lo_q :
		sel_hi ? {16'h0, instr_hi_q} :
		sel_ctrl ? {28'h0, ctrl_q, 1'b0} :
		sel_stat ? {29'h0, err_q, done_q, ~idle} :
		sel_usel ? {27'h0, usel_q} :
		sel_ux ? rb_x :
		sel_uy ? rb_y : 32'h0;

	assign dec_bus.instr = {instr_hi_q, instr_lo_q};
	assign dec_bus.simd = mode_now[mmx_pkg::CTRL_SIMD - 1];
	assign dec_bus.bcast = mode_now[mmx_pkg::CTRL_BCAST - 1];
	assign dec_bus.short_w = mode_now[mmx_pkg::CTRL_SHORT - 1];
	assign dec_bus.idx_val = ri;

	mmx_decode u_dec
	(
		.d(dec_bus)
	);

	mmx_ureg #(.N(32), .W(32)) u_ureg
	(
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_wx_en(wx_mem | wx_sw),
		.i_wy_en(wy_mem | wy_sw),
		.i_w_addr(w_addr),
		.i_w_data(w_data),
		.i_ra_addr(dec_bus.ureg),
		.o_ra_x(ra_x),
		.o_ra_y(ra_y),
		.i_rb_addr(usel_q),
		.o_rb_x(rb_x),
		.o_rb_y(rb_y),
		.i_ri_addr(dec_bus.idx_sel),
		.o_ri(ri)
	);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			S_IDLE:
			begin
				if (launch)
					state_d = S_X;
			end
			S_X:
			begin
				if (i_mem_ack)
					state_d = dec_bus.y_en ? S_Y : S_IDLE;
			end
			S_Y:
			begin
				if (i_mem_ack)
					state_d = S_IDLE;
			end
			default:
			begin
				state_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
			state_q <= S_IDLE;
			done_q <= 1'b0;
			err_q <= 1'b0;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			if (rd_go)
				rdata_q <= rd_mux;
			state_q <= state_d;
			done_q <= done_d;
			err_q <= err_d;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			instr_lo_q <= 32'h0;
			instr_hi_q <= 16'h0;
			ctrl_q <= mmx_pkg::CTRL_RESET;
			usel_q <= 5'h0;
		end
		else if (wr_ok)
		begin
			if (sel_lo)
				instr_lo_q <= be_merge(instr_lo_q, i_avs_writedata, i_avs_byteenable);
			if (sel_hi)
				instr_hi_q <= hi_wr[15:0];
			if (sel_ctrl)
				ctrl_q <= ctrl_wr[3:1];
			if (sel_usel && i_avs_byteenable[0])
				usel_q <= i_avs_writedata[4:0];
		end
	end

	// Addresses are latched at launch so the index is read once, never updated
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			addr_q <= 32'h0;
			addr_y_q <= 32'h0;
			wdata_q <= 32'h0;
			pe_q <= 1'b0;
			space_q <= 1'b0;
			we_q <= 1'b0;
			lw_q <= 1'b0;
		end
		else if (launch)
		begin
			addr_q <= dec_bus.addr_x;
			addr_y_q <= dec_bus.addr_y;
			wdata_q <= ra_x;
			pe_q <= 1'b0;
			space_q <= dec_bus.space;
			we_q <= dec_bus.dir;
			lw_q <= dec_bus.lw;
		end
		else if (x_ack && dec_bus.y_en)
		begin
			addr_q <= addr_y_q;
			wdata_q <= ra_y;
			pe_q <= 1'b1;
		end
	end

	assign o_mem_req = (state_q == S_X) | (state_q == S_Y);
	assign o_mem_space = space_q;
	assign o_mem_we = we_q;
	assign o_mem_lw = lw_q;
	assign o_mem_pe = pe_q;
	assign o_mem_addr = addr_q;
	assign o_mem_wdata = wdata_q;
	assign o_instr_size = dec_bus.size_bits;
endmodule // mmx_exec
`default_nettype wire

// ### rtl/mmx_ureg.sv
`default_nettype none
module mmx_ureg
#(
	parameter int N = 32,
	parameter int W = 32
)
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_wx_en,
	input wire logic i_wy_en,
	input wire logic [4:0] i_w_addr,
	input wire logic [W-1:0] i_w_data,
	input wire logic [4:0] i_ra_addr,
	output logic [W-1:0] o_ra_x,
	output logic [W-1:0] o_ra_y,
	input wire logic [4:0] i_rb_addr,
	output logic [W-1:0] o_rb_x,
	output logic [W-1:0] o_rb_y,
	input wire logic [2:0] i_ri_addr,
	output logic [W-1:0] o_ri
);
	logic [W-1:0] x_q [N];
	logic [W-1:0] y_q [N];

	always_ff @(posedge i_clk)
	begin
		for (int i = 0; i < N; i++)
		begin
			if (!i_rstn)
			begin
				x_q[i] <= '0;
				y_q[i] <= '0;
			end
			else
			begin
				if (i_wx_en && (i_w_addr == i[4:0]))
					x_q[i] <= i_w_data;
				if (i_wy_en && (i_w_addr == i[4:0]))
					y_q[i] <= i_w_data;
			end
		end
	end

	assign o_ra_x = x_q[i_ra_addr];
	assign o_ra_y = y_q[i_ra_addr];
	assign o_rb_x = x_q[i_rb_addr];
	assign o_rb_y = y_q[i_rb_addr];
	assign o_ri = x_q[{2'h0, i_ri_addr}];
endmodule // mmx_ureg
`default_nettype wire

// ### tb/mmx_exec_sva.sv
`default_nettype none
module mmx_exec_sva
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic o_avs_waitrequest,
	input wire logic o_mem_req,
	input wire logic i_mem_ack,
	input wire logic o_mem_space,
	input wire logic o_mem_we,
	input wire logic o_mem_lw,
	input wire logic o_mem_pe,
	input wire logic [31:0] o_mem_addr,
	input wire logic [31:0] o_mem_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	wire logic rq = i_avs_read | i_avs_write;
	wire logic x_ack = o_mem_req & i_mem_ack & ~o_mem_pe;
	wire logic y_ack = o_mem_req & i_mem_ack & o_mem_pe;
	a_wait_once: assert property ($rose(rq) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
		else $error("bus access not answered after one cycle");
	a_wait_idle: assert property (!rq |-> !o_avs_waitrequest)
		else $error("waitrequest without a request");
	a_mem_hold: assert property (o_mem_req && !i_mem_ack |=> o_mem_req
		&& $stable(o_mem_addr)
		&& $stable({o_mem_pe, o_mem_we, o_mem_space, o_mem_lw, o_mem_wdata}))
		else $error("memory request changed before ack");
	a_start_x: assert property ($rose(o_mem_req) |-> !o_mem_pe)
		else $error("move did not start on first element");
	a_x_then_y: assert property (x_ack |=> !o_mem_req || o_mem_pe)
		else $error("second access not on second element");
	a_y_skew: assert property (x_ack ##1 o_mem_req |->
		(o_mem_addr - $past(o_mem_addr)) inside {32'h0, 32'h1, 32'h2})
		else $error("second element address skew out of range");
	a_y_same: assert property (x_ack ##1 o_mem_req |-> o_mem_we == $past(o_mem_we)
		&& o_mem_space == $past(o_mem_space) && o_mem_lw == $past(o_mem_lw))
		else $error("second element access differs in kind");
	a_y_last: assert property (y_ack |=> !o_mem_req)
		else $error("access after second element");
	c_simd: cover property (y_ack);
	c_single: cover property (x_ack ##1 !o_mem_req);
	c_read: cover property (i_avs_read && !o_avs_waitrequest);
endmodule // mmx_exec_sva
bind mmx_exec mmx_exec_sva u_sva (.i_clk(i_clk), .i_rstn(i_rstn), .i_avs_read(i_avs_read),
	.i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest), .o_mem_req(o_mem_req),
	.i_mem_ack(i_mem_ack), .o_mem_space(o_mem_space), .o_mem_we(o_mem_we),
	.o_mem_lw(o_mem_lw), .o_mem_pe(o_mem_pe), .o_mem_addr(o_mem_addr),
	.o_mem_wdata(o_mem_wdata));
`default_nettype wire

// ### tb/mmx_mem_model.sv
`default_nettype none
module mmx_mem_model
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_req,
	input wire logic i_space,
	input wire logic i_we,
	input wire logic i_lw,
	input wire logic i_pe,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_lat,
	output logic o_ack,
	output logic [31:0] o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q;
	logic [31:0] addr_q [2];
	logic [31:0] wd_q [2];
	logic [2:0] flags_q;
	int n_acc = 0;
	always_ff @(posedge i_clk)
	begin
		// Idle data toggles so a stale sample never looks right
		o_rdata <= i_rstn ? ~o_rdata : 32'h0;
		if (!i_rstn || !i_req || o_ack)
		begin
			cnt_q <= 4'h0;
			o_ack <= 1'b0;
		end
		else if (cnt_q == i_lat)
		begin
			o_ack <= 1'b1;
			o_rdata <= ~i_addr ^ {i_space, 31'h0};
		end
		else
			cnt_q <= cnt_q + 4'h1;
		if (i_req && o_ack)
		begin
			addr_q[i_pe] <= i_addr;
			wd_q[i_pe] <= i_wdata;
			flags_q <= {i_we, i_lw, i_space};
			n_acc <= n_acc + 1;
		end
	end
endmodule // mmx_mem_model
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [7:0] adr = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] lat = 4'h0;
	logic wreq, mreq, msp, mwe, mlw, mpe, mack;
	logic [31:0] maddr, mwd, mrd, rdat, junk, q, a, x, y;
	logic [5:0] isz;
	logic [5:0] sz_tab [4] = '{mmx_pkg::SIZE_A, mmx_pkg::SIZE_B, mmx_pkg::SIZE_C, 6'h00};
	logic [2:0] kmode [3] = '{3'h1, 3'h3, 3'h5};
	logic [31:0] kval [3] = '{mmx_pkg::K_NW, mmx_pkg::K_BCAST, mmx_pkg::K_SW};
	int error_cnt = 0;
	int n_checks = 0;
	int base;
	always #4 i_clk = ~i_clk;
	mmx_exec dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_mem_req(mreq), .i_mem_ack(mack),
		.o_mem_space(msp), .o_mem_we(mwe), .o_mem_lw(mlw), .o_mem_pe(mpe), .o_mem_addr(maddr),
		.o_mem_wdata(mwd), .i_mem_rdata(mrd), .o_instr_size(isz));
	mmx_mem_model mem (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(mreq), .i_space(msp), .i_we(mwe),
		.i_lw(mlw), .i_pe(mpe), .i_addr(maddr), .i_wdata(mwd), .i_lat(lat), .o_ack(mack),
		.o_rdata(mrd));
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge i_clk);
		adr <= ad;
		wr <= w;
		rd <= !w;
		wdat <= d;
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (wreq !== 1'b0 && n < 100);
		if (wreq !== 1'b0)
		begin
			error_cnt++;
			wrap_up();
		end
		r = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic setu(input logic [4:0] u, input logic [31:0] vx, input logic [31:0] vy);
		bus(1'b1, mmx_pkg::OFS_USEL, {27'h0, u}, junk);
		bus(1'b1, mmx_pkg::OFS_UREG_X, vx, junk);
		bus(1'b1, mmx_pkg::OFS_UREG_Y, vy, junk);
	endtask
	task automatic getu(input logic [4:0] u);
		bus(1'b1, mmx_pkg::OFS_USEL, {27'h0, u}, junk);
		bus(1'b0, mmx_pkg::OFS_UREG_X, 32'h0, x);
		bus(1'b0, mmx_pkg::OFS_UREG_Y, 32'h0, y);
	endtask
	function automatic logic [47:0] mk(input logic [3:0] op, input logic [1:0] sfx,
		input logic sp, dir, lw, input logic [4:0] u, input logic [1:0] ix, input logic [31:0] v);
		return {op, sfx, sp, dir, lw, u, ix, v};
	endfunction
	// Mode is {short, broadcast, simd}; memory latency shifts on every move
	task automatic run(input logic [47:0] ins, input logic [2:0] mode);
		int n;
		lat <= lat + 4'h3;
		bus(1'b1, mmx_pkg::OFS_INSTR_LO, ins[31:0], junk);
		bus(1'b1, mmx_pkg::OFS_INSTR_HI, {16'h0, ins[47:32]}, junk);
		base = mem.n_acc;
		bus(1'b1, mmx_pkg::OFS_CTRL, {28'h0, mode, 1'b1}, junk);
		n = 0;
		do
		begin
			bus(1'b0, mmx_pkg::OFS_STATUS, 32'h0, q);
			n++;
		end
		while (q[mmx_pkg::ST_DONE] !== 1'b1 && n < 40);
		if (q[mmx_pkg::ST_DONE] !== 1'b1)
		begin
			error_cnt++;
			wrap_up();
		end
		`CHK("err", 1'b0, q[mmx_pkg::ST_ERR]);
		bus(1'b1, mmx_pkg::OFS_STATUS, 32'h6, junk);
	endtask
	initial
	begin
		repeat (10) @(posedge i_clk);
		i_rstn <= 1'b1;
		for (int s = 0; s < 4; s++)
		begin
			bus(1'b1, mmx_pkg::OFS_INSTR_HI, {20'h0, s[1:0], 10'h0}, junk);
			@(negedge i_clk);
			`CHK("size", sz_tab[s], isz);
		end
		bus(1'b0, 8'h40, 32'h0, q);
		`CHK("unmapped", 32'h0, q);
		setu(5'h08, 32'h1111_2222, 32'h3333_4444);
		setu(5'h14, 32'ha5a5_a5a5, 32'h0);
		run(mk(mmx_pkg::OP_DIRECT, mmx_pkg::SFX_A, 1'b1, 1'b1, 1'b1, 5'h08, 2'h0,
			32'hffff_ffff), 3'h1);
		`CHK("n_acc", base + 2, mem.n_acc);
		`CHK("x addr", 32'hffff_ffff, mem.addr_q[0]);
		`CHK("y addr", 32'h0, mem.addr_q[1]);
		`CHK("x data", 32'h1111_2222, mem.wd_q[0]);
		`CHK("y data", 32'h3333_4444, mem.wd_q[1]);
		`CHK("flags", 3'h7, mem.flags_q);
		for (int m = 0; m < 3; m++)
		begin
			a = 32'h1234_5670 + 32'(m);
			run(mk(mmx_pkg::OP_DIRECT, mmx_pkg::SFX_A, 1'b0, 1'b0, 1'b0, 5'h08, 2'h0, a),
				kmode[m]);
			getu(5'h08);
			`CHK("load x", ~a, x);
			`CHK("load y", ~(a + kval[m]), y);
		end
		run(mk(mmx_pkg::OP_DIRECT, mmx_pkg::SFX_A, 1'b0, 1'b1, 1'b0, 5'h14, 2'h0, 32'h40),
			3'h1);
		`CHK("single", base + 1, mem.n_acc);
		`CHK("single data", 32'ha5a5_a5a5, mem.wd_q[0]);
		run(mk(mmx_pkg::OP_DIRECT, mmx_pkg::SFX_A, 1'b0, 1'b1, 1'b0, 5'h08, 2'h0, 32'h50),
			3'h0);
		`CHK("sisd", base + 1, mem.n_acc);
		`CHK("flags", 3'h4, mem.flags_q);
		setu(5'h01, 32'h8000_0000, 32'h0);
		run(mk(mmx_pkg::OP_INDIRECT, mmx_pkg::SFX_A, 1'b0, 1'b0, 1'b0, 5'h09, 2'h1,
			32'h9000_0001), 3'h1);
		`CHK("ind x", 32'h1000_0001, mem.addr_q[0]);
		`CHK("ind y", 32'h1000_0002, mem.addr_q[1]);
		getu(5'h09);
		`CHK("ind data", ~32'h1000_0001, x);
		getu(5'h01);
		`CHK("index kept", 32'h8000_0000, x);
		setu(5'h06, 32'h0000_0100, 32'h0);
		setu(5'h0a, 32'hcafe_0001, 32'h0);
		// Moved register sits outside the generator's index range
		run(mk(mmx_pkg::OP_INDIRECT, mmx_pkg::SFX_B, 1'b1, 1'b1, 1'b0, 5'h0a, 2'h2,
			32'hffff_ff85), 3'h0);
		`CHK("short addr", 32'h105, mem.addr_q[0]);
		`CHK("short data", 32'hcafe_0001, mem.wd_q[0]);
		// Same-generator register is refused: error flag, no access
		bus(1'b1, mmx_pkg::OFS_INSTR_HI, {16'h0, mmx_pkg::OP_INDIRECT, mmx_pkg::SFX_A, 3'h0,
			5'h02, 2'h0}, junk);
		base = mem.n_acc;
		bus(1'b1, mmx_pkg::OFS_CTRL, 32'h1, junk);
		bus(1'b0, mmx_pkg::OFS_STATUS, 32'h0, q);
		`CHK("refused", 32'h4, q);
		`CHK("no access", base, mem.n_acc);
		bus(1'b1, mmx_pkg::OFS_STATUS, 32'h6, junk);
		bus(1'b0, mmx_pkg::OFS_STATUS, 32'h0, q);
		`CHK("cleared", 32'h0, q);
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
